// File: logic/chgset_top.sv
`timescale 1ns/1ps
`default_nettype none
module chgset_top #(
	// arbitrary neutral bus address
	parameter logic [6:0] DEVICE_ADDRESS = 7'h2a
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// serial configuration bus, open drain data
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic sda_level,
	output logic sda_oe,
	// battery voltage comparators
	input wire logic above_dead_battery_threshold,
	input wire logic above_short_battery_threshold,
	input wire logic above_low_battery_threshold,
	input wire logic above_termination_voltage,
	// mode requests
	input wire logic charge_request,
	input wire logic on_the_go_request,
	input wire logic high_impedance_request,
	// regulation loop feedback
	input wire logic input_limit_reached,
	// safety timer base tick, same clock
	input wire logic base_timer_tick,
	// setpoint outputs
	output logic [6:0] charge_current_percent,
	output logic dead_battery_current_on,
	output logic [6:0] input_limit_percent,
	output logic input_limit_enable,
	output logic [2:0] charge_phase,
	output logic charge_mode,
	output logic on_the_go_mode,
	output logic input_current_limit_flag,
	output logic safety_timer_tick
);

	// ==========================================================
	// synchronisers
	logic [chgset_pkg::SYNC_W-1:0] raw_in;
	logic [chgset_pkg::SYNC_W-1:0] sync1_r, sync2_r;
	logic scl_d_r, sda_d_r;
	assign raw_in = {input_limit_reached, above_termination_voltage,
		above_low_battery_threshold, above_short_battery_threshold,
		above_dead_battery_threshold, charge_request, on_the_go_request,
		high_impedance_request, scl_pin, sda_pin};
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
			scl_d_r <= sync2_r[1];
			sda_d_r <= sync2_r[0];
		end
	end
	logic scl_s, sda_s, idle_s, go_s, chg_s;
	logic dead_s, short_s, low_s, term_s, lim_s;
	assign {lim_s, term_s, low_s, short_s, dead_s, chg_s, go_s, idle_s,
		scl_s, sda_s} = sync2_r;

	// ==========================================================
	// shared decode
	function automatic logic [6:0] clamp_pct(input logic [6:0] f);
		if (f == chgset_pkg::PCT_ZERO) begin
			clamp_pct = chgset_pkg::PCT_MIN;
		end else if (f > chgset_pkg::PCT_MAX) begin
			clamp_pct = chgset_pkg::PCT_MAX;
		end else begin
			clamp_pct = f;
		end
	endfunction : clamp_pct

	// ==========================================================
	// serial bus slave and register file
	chgset_pkg::chgset_bus_type bs_r, bs_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic rw_r, rw_nxt;
	logic ptr_phase_r, ptr_phase_nxt;
	logic oe_r, oe_nxt;
	logic [6:0] charge_scale_field_r, charge_scale_field_nxt;
	logic [6:0] input_limit_scale_field_r, input_limit_scale_field_nxt;
	logic [1:0] short_sel_r, short_sel_nxt;
	logic [1:0] pre_sel_r, pre_sel_nxt;
	logic [7:0] status_byte;
	logic [7:0] rd_data;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	chgset_pkg::chgset_phase_type phase_r, phase_nxt;
	chgset_pkg::chgset_mode_type mode_r, mode_nxt;
	logic flag_r, flag_nxt;

	assign scl_rise = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

	always_comb begin
		status_byte = 8'h00;
		status_byte[chgset_pkg::STAT_ILIM_BIT] = flag_r;
		status_byte[chgset_pkg::STAT_PHASE_LSB +: 3] = phase_r;
		status_byte[chgset_pkg::STAT_CHARGE_BIT] = (mode_r ==
			chgset_pkg::MD_CHARGE);
		status_byte[chgset_pkg::STAT_ON_THE_GO_BIT] = (mode_r ==
			chgset_pkg::MD_ON_THE_GO);
		// unmapped offsets read as zero
		if (ptr_r == chgset_pkg::REG_OPERATING_STATUS) begin
			rd_data = status_byte;
		end else if (ptr_r == chgset_pkg::REG_SHORT_BATTERY_CURRENT_SELECT) begin
			rd_data = {6'h00, short_sel_r};
		end else if (ptr_r == chgset_pkg::REG_INPUT_LIMIT_SCALE) begin
			rd_data = {1'b0, input_limit_scale_field_r};
		end else if (ptr_r == chgset_pkg::REG_FAST_CHARGE_SCALE) begin
			rd_data = {1'b0, charge_scale_field_r};
		end else if (ptr_r == chgset_pkg::REG_PRECHARGE_CURRENT_SELECT) begin
			rd_data = {6'h00, pre_sel_r};
		end else begin
			rd_data = 8'h00;
		end
	end

	always_comb begin
		bs_nxt = bs_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		ptr_phase_nxt = ptr_phase_r;
		oe_nxt = oe_r;
		charge_scale_field_nxt = charge_scale_field_r;
		input_limit_scale_field_nxt = input_limit_scale_field_r;
		short_sel_nxt = short_sel_r;
		pre_sel_nxt = pre_sel_r;
		if (bus_start) begin
			bs_nxt = chgset_pkg::BS_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt = 1'b0;
		end else if (bus_stop) begin
			bs_nxt = chgset_pkg::BS_IDLE;
			oe_nxt = 1'b0;
		end else begin
			case (bs_r)
				chgset_pkg::BS_ADDR, chgset_pkg::BS_WRITE: begin
					if (scl_rise && cnt_r < chgset_pkg::BITS_PER_BYTE) begin
						shift_nxt = {shift_r[6:0], sda_s};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == chgset_pkg::BITS_PER_BYTE) begin
						bs_nxt = chgset_pkg::BS_ACK;
						oe_nxt = 1'b1;
						if (bs_r == chgset_pkg::BS_ADDR) begin
							rw_nxt = shift_r[0];
							ptr_phase_nxt = ~shift_r[0];
							if (shift_r[7:1] != DEVICE_ADDRESS) begin
								bs_nxt = chgset_pkg::BS_IDLE;
								oe_nxt = 1'b0;
							end
						end else if (ptr_phase_r) begin
							ptr_nxt = shift_r;
							ptr_phase_nxt = 1'b0;
						end else begin
							ptr_nxt = ptr_r + 8'h01;
							// whole seven-bit scale value kept for read-back, two bits for the selects
							// store any value
							if (ptr_r == chgset_pkg::REG_FAST_CHARGE_SCALE) begin
								charge_scale_field_nxt = shift_r[6:0];
							end else if (ptr_r == chgset_pkg::REG_INPUT_LIMIT_SCALE) begin
								input_limit_scale_field_nxt = shift_r[6:0];
							end else if (ptr_r ==
								chgset_pkg::REG_SHORT_BATTERY_CURRENT_SELECT) begin
								short_sel_nxt = shift_r[1:0];
							end else if (ptr_r ==
								chgset_pkg::REG_PRECHARGE_CURRENT_SELECT) begin
								pre_sel_nxt = shift_r[1:0];
							end
						end
					end
				end
				chgset_pkg::BS_ACK: begin
					if (scl_fall) begin
						cnt_nxt = 4'h0;
						oe_nxt = 1'b0;
						if (rw_r) begin
							shift_nxt = rd_data;
							ptr_nxt = ptr_r + 8'h01;
							oe_nxt = ~rd_data[7];
							bs_nxt = chgset_pkg::BS_READ;
						end else begin
							bs_nxt = chgset_pkg::BS_WRITE;
						end
					end
				end
				chgset_pkg::BS_READ: begin
					if (scl_fall) begin
						if (cnt_r == chgset_pkg::LAST_BIT) begin
							oe_nxt = 1'b0;
							bs_nxt = chgset_pkg::BS_MACK;
						end else begin
							cnt_nxt = cnt_r + 4'h1;
							shift_nxt = {shift_r[6:0], 1'b0};
							oe_nxt = ~shift_r[6];
						end
					end
				end
				chgset_pkg::BS_MACK: begin
					// a not-acknowledge from the host ends the read burst
					if (scl_rise) begin
						bs_nxt = sda_s ? chgset_pkg::BS_IDLE : chgset_pkg::BS_LOAD;
					end
				end
				chgset_pkg::BS_LOAD: begin
					if (scl_fall) begin
						cnt_nxt = 4'h0;
						shift_nxt = rd_data;
						ptr_nxt = ptr_r + 8'h01;
						oe_nxt = ~rd_data[7];
						bs_nxt = chgset_pkg::BS_READ;
					end
				end
				default: begin
					bs_nxt = chgset_pkg::BS_IDLE;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bs_r <= chgset_pkg::BS_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			ptr_phase_r <= 1'b0;
			oe_r <= 1'b0;
			charge_scale_field_r <= chgset_pkg::CHARGE_SCALE_RESET;
			input_limit_scale_field_r <= chgset_pkg::INPUT_LIMIT_RESET;
			short_sel_r <= chgset_pkg::SELECT_RESET;
			pre_sel_r <= chgset_pkg::SELECT_RESET;
		end else begin
			bs_r <= bs_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			ptr_phase_r <= ptr_phase_nxt;
			oe_r <= oe_nxt;
			charge_scale_field_r <= charge_scale_field_nxt;
			input_limit_scale_field_r <= input_limit_scale_field_nxt;
			short_sel_r <= short_sel_nxt;
			pre_sel_r <= pre_sel_nxt;
		end
	end
	assign sda_level = 1'b0;
	assign sda_oe = oe_r;

	// ==========================================================
	// operating mode, phase and setpoints
	logic [6:0] chg_pct_r, chg_pct_nxt;
	logic [6:0] lim_pct_r, lim_pct_nxt;
	logic dead_r, dead_nxt;
	logic half_r, half_nxt;
	logic tick_r, tick_nxt;

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			chgset_pkg::MD_IDLE: begin
				if (!idle_s && go_s) begin
					mode_nxt = chgset_pkg::MD_ON_THE_GO;
				end else if (!idle_s && chg_s) begin
					mode_nxt = chgset_pkg::MD_CHARGE;
				end
			end
			chgset_pkg::MD_CHARGE: begin
				if (idle_s || !chg_s) begin
					mode_nxt = chgset_pkg::MD_IDLE;
				end
			end
			chgset_pkg::MD_ON_THE_GO: begin
				if (idle_s || !go_s) begin
					mode_nxt = chgset_pkg::MD_IDLE;
				end
			end
			default: begin
				mode_nxt = chgset_pkg::MD_IDLE;
			end
		endcase

		if (!dead_s) begin
			phase_nxt = chgset_pkg::PH_DEAD;
		end else if (!short_s) begin
			phase_nxt = chgset_pkg::PH_SHORT;
		end else if (!low_s) begin
			phase_nxt = chgset_pkg::PH_PRECOND;
		end else if (!term_s) begin
			phase_nxt = chgset_pkg::PH_FAST;
		end else begin
			phase_nxt = chgset_pkg::PH_DONE;
		end

		dead_nxt = 1'b0;
		chg_pct_nxt = chgset_pkg::PCT_ZERO;
		case (phase_r)
			chgset_pkg::PH_DEAD: begin
				dead_nxt = 1'b1;
			end
			chgset_pkg::PH_SHORT: begin
				case (short_sel_r)
					2'h0: chg_pct_nxt = chgset_pkg::SHORT_PCT_1;
					2'h1: chg_pct_nxt = chgset_pkg::SHORT_PCT_2;
					2'h2: chg_pct_nxt = chgset_pkg::SHORT_PCT_4;
					default: chg_pct_nxt = chgset_pkg::SHORT_PCT_8;
				endcase
			end
			chgset_pkg::PH_PRECOND: begin
				case (pre_sel_r)
					2'h0: chg_pct_nxt = chgset_pkg::PRE_PCT_5;
					2'h1: chg_pct_nxt = chgset_pkg::PRE_PCT_10;
					2'h2: chg_pct_nxt = chgset_pkg::PRE_PCT_15;
					default: chg_pct_nxt = chgset_pkg::PRE_PCT_20;
				endcase
			end
			chgset_pkg::PH_FAST: begin
				chg_pct_nxt = clamp_pct(charge_scale_field_r);
			end
			default: begin
				chg_pct_nxt = chgset_pkg::PCT_ZERO;
			end
		endcase
		// charge setpoint and trickle stand at zero outside charge mode
		if (mode_r != chgset_pkg::MD_CHARGE) begin
			chg_pct_nxt = chgset_pkg::PCT_ZERO;
			dead_nxt = 1'b0;
		end

		lim_pct_nxt = clamp_pct(input_limit_scale_field_r);
		flag_nxt = lim_s && (mode_r == chgset_pkg::MD_CHARGE);

		half_nxt = half_r;
		tick_nxt = 1'b0;
		if (base_timer_tick) begin
			half_nxt = flag_r ? ~half_r : 1'b0;
			tick_nxt = ~flag_r | half_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_r <= chgset_pkg::MD_IDLE;
			phase_r <= chgset_pkg::PH_DEAD;
			chg_pct_r <= chgset_pkg::PCT_ZERO;
			lim_pct_r <= chgset_pkg::PCT_MIN;
			dead_r <= 1'b0;
			flag_r <= 1'b0;
			half_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			phase_r <= phase_nxt;
			chg_pct_r <= chg_pct_nxt;
			lim_pct_r <= lim_pct_nxt;
			dead_r <= dead_nxt;
			flag_r <= flag_nxt;
			half_r <= half_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign charge_current_percent = chg_pct_r;
	assign dead_battery_current_on = dead_r;
	assign input_limit_percent = lim_pct_r;
	assign input_limit_enable = (mode_r == chgset_pkg::MD_CHARGE);
	assign charge_phase = phase_r;
	assign charge_mode = (mode_r == chgset_pkg::MD_CHARGE);
	assign on_the_go_mode = (mode_r == chgset_pkg::MD_ON_THE_GO);
	assign input_current_limit_flag = flag_r;
	assign safety_timer_tick = tick_r;

endmodule : chgset_top
`default_nettype wire

// File: logic/chgset_pkg.sv
// How it works
// - phase follows rising battery voltage comparators
// - dead battery phase forces fixed trickle command
// - short phase uses 1/2/4/8 percent selector
// - precharge phase uses 5 to 20 percent
// - charge scale stores any seven-bit value
// - charge scale zero applies one percent
// - charge scale above 100 clamps to 100
// - input limit percent from seven-bit field
// - input limit zero applies one percent
// - input limit above 100 clamps to 100
// - status flag high while input limiting
// - safety timers tick half rate while limiting
// - input limiting only in charge mode
// - charge entered from idle, on-the-go wins
package chgset_pkg;

	// ==========================================================
	// register map (byte offsets on the serial bus)
	localparam logic [7:0] REG_OPERATING_STATUS = 8'h03;
	localparam logic [7:0] REG_SHORT_BATTERY_CURRENT_SELECT = 8'h0b;
	localparam logic [7:0] REG_INPUT_LIMIT_SCALE = 8'h17;
	localparam logic [7:0] REG_FAST_CHARGE_SCALE = 8'h18;
	localparam logic [7:0] REG_PRECHARGE_CURRENT_SELECT = 8'h19;

	// ==========================================================
	// reset values
	localparam logic [6:0] CHARGE_SCALE_RESET = 7'h64;
	localparam logic [6:0] INPUT_LIMIT_RESET = 7'h64;
	localparam logic [1:0] SELECT_RESET = 2'h0;

	// ==========================================================
	// percent limits
	localparam logic [6:0] PCT_MIN = 7'h01;
	localparam logic [6:0] PCT_MAX = 7'h64;
	localparam logic [6:0] PCT_ZERO = 7'h00;
	localparam logic [6:0] SHORT_PCT_1 = 7'h01;
	localparam logic [6:0] SHORT_PCT_2 = 7'h02;
	localparam logic [6:0] SHORT_PCT_4 = 7'h04;
	localparam logic [6:0] SHORT_PCT_8 = 7'h08;
	localparam logic [6:0] PRE_PCT_5 = 7'h05;
	localparam logic [6:0] PRE_PCT_10 = 7'h0a;
	localparam logic [6:0] PRE_PCT_15 = 7'h0f;
	localparam logic [6:0] PRE_PCT_20 = 7'h14;

	// ==========================================================
	// status register field positions
	localparam int STAT_ILIM_BIT = 0;
	localparam int STAT_PHASE_LSB = 1;
	localparam int STAT_CHARGE_BIT = 4;
	localparam int STAT_ON_THE_GO_BIT = 5;

	// ==========================================================
	// serial bus constants
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam int SYNC_W = 10;

	typedef enum logic [2:0] {
		PH_DEAD = 3'h0,
		PH_SHORT = 3'h1,
		PH_PRECOND = 3'h2,
		PH_FAST = 3'h3,
		PH_DONE = 3'h4
	} chgset_phase_type;

	typedef enum logic [1:0] {
		MD_IDLE = 2'h0,
		MD_CHARGE = 2'h1,
		MD_ON_THE_GO = 2'h2
	} chgset_mode_type;

	typedef enum logic [2:0] {
		BS_IDLE = 3'h0,
		BS_ADDR = 3'h1,
		BS_WRITE = 3'h2,
		BS_ACK = 3'h3,
		BS_READ = 3'h4,
		BS_MACK = 3'h5,
		BS_LOAD = 3'h6
	} chgset_bus_type;

endpackage : chgset_pkg

// File: verification/chgset_host.sv
`timescale 1ns/1ps
`default_nettype none
module chgset_host (
	// clock and resolved data wire
	input wire logic clk,
	input wire logic sda,
	// driven bus lines
	output logic scl,
	output logic sda_oe
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk);
	endtask : hw
	// ======================================================
	// bus phases, each level held at least four core cycles
	task automatic start();
		sda_oe = 1'b0;
		hw(4);
		scl = 1'b1;
		hw(6);
		sda_oe = 1'b1;
		hw(6);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		hw(2);
		sda_oe = 1'b1;
		hw(4);
		scl = 1'b1;
		hw(6);
		sda_oe = 1'b0;
		hw(6);
	endtask : stop
	// data moves only while the bus clock is low, so no false start
	task automatic put(input logic b, output logic r);
		hw(2);
		sda_oe = !b;
		hw(4);
		scl = 1'b1;
		hw(6);
		r = sda;
		scl = 1'b0;
	endtask : put
	task automatic xfer(input logic [7:0] d, input logic a,
			output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) put(d[i], q[i]);
		put(a, k);
	endtask : xfer
endmodule : chgset_host
`default_nettype wire

// File: verification/chgset_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module chgset_top_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// watched ports
	input wire logic base_timer_tick,
	input wire logic [6:0] charge_current_percent,
	input wire logic dead_battery_current_on,
	input wire logic [6:0] input_limit_percent,
	input wire logic input_limit_enable,
	input wire logic [2:0] charge_phase,
	input wire logic charge_mode,
	input wire logic on_the_go_mode,
	input wire logic input_current_limit_flag,
	input wire logic safety_timer_tick
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ======================================================
	// setpoints lag phase and mode by one cycle, hence two samples
	a_dead_trickle: assert property (
		(charge_mode && charge_phase == 3'h0)[*2] |->
		dead_battery_current_on && charge_current_percent == 7'h00)
		else $error("dead setpoint wrong");
	a_short_pick: assert property (
		(charge_mode && charge_phase == 3'h1)[*2] |->
		charge_current_percent inside {7'h01, 7'h02, 7'h04, 7'h08})
		else $error("short setpoint wrong");
	a_pre_pick: assert property (
		(charge_mode && charge_phase == 3'h2)[*2] |->
		charge_current_percent inside {7'h05, 7'h0a, 7'h0f, 7'h14})
		else $error("precharge setpoint wrong");
	a_fast_clamp: assert property (
		(charge_mode && charge_phase == 3'h3)[*2] |->
		charge_current_percent inside {[7'h01:7'h64]})
		else $error("fast setpoint out of range");
	a_done_zero: assert property (
		(charge_mode && charge_phase == 3'h4)[*2] |->
		charge_current_percent == 7'h00 && !dead_battery_current_on)
		else $error("terminated setpoint not zero");
	a_ilim_range: assert property (
		input_limit_percent inside {[7'h01:7'h64]})
		else $error("input limit out of range");
	a_limit_mode: assert property (
		input_limit_enable == charge_mode)
		else $error("limit enable outside charge");
	a_flag_mode: assert property (
		input_current_limit_flag |-> $past(charge_mode))
		else $error("limit flag outside charge");
	a_tick_cause: assert property (
		safety_timer_tick |-> $past(base_timer_tick))
		else $error("timer tick without cause");
	a_mode_excl: assert property (
		!(charge_mode && on_the_go_mode))
		else $error("charge and on-the-go together");
	a_charge_entry: assert property (
		$rose(charge_mode) |-> !$past(on_the_go_mode))
		else $error("charge entered from on-the-go");
	c_limited_tick: cover property (input_current_limit_flag &&
		safety_timer_tick);
	c_on_the_go: cover property (on_the_go_mode);
	c_fast: cover property (charge_mode && charge_phase == 3'h3);
endmodule : chgset_top_chk
bind chgset_top chgset_top_chk i_chk (.*);
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [6:0] DEV = 7'h2a;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic scl, host_oe, sda_o, sda_oe, dead_on, ile, cm, om, flag, stk;
	logic [6:0] pct, ilp, cs, ils;
	logic [2:0] ph;
	logic [3:0] lvl = 4'h0;
	logic chg = 1'b0, go = 1'b0, idle = 1'b0, lim = 1'b0, tick = 1'b0;
	logic [1:0] ss, sp;
	logic [31:0] seed = 32'h5effd050;
	logic [6:0] corner [4] = '{7'h00, 7'h64, 7'h65, 7'h7f};
	int fails = 0, num_checks = 0, cyc = 0, ticks = 0;
	// pulled-up open-drain data line
	wire sda = !(host_oe || (sda_oe && !sda_o));
	always #2.5 core_clk = !core_clk;
	chgset_top #(.DEVICE_ADDRESS(DEV)) i_dut (.core_clk(core_clk),
		.rst(rst), .scl_pin(scl), .sda_pin(sda), .sda_level(sda_o),
		.sda_oe(sda_oe), .above_dead_battery_threshold(lvl[0]),
		.above_short_battery_threshold(lvl[1]),
		.above_low_battery_threshold(lvl[2]),
		.above_termination_voltage(lvl[3]), .charge_request(chg),
		.on_the_go_request(go), .high_impedance_request(idle),
		.input_limit_reached(lim), .base_timer_tick(tick),
		.charge_current_percent(pct), .dead_battery_current_on(dead_on),
		.input_limit_percent(ilp), .input_limit_enable(ile),
		.charge_phase(ph), .charge_mode(cm), .on_the_go_mode(om),
		.input_current_limit_flag(flag), .safety_timer_tick(stk));
	chgset_host i_host (.clk(core_clk), .sda(sda), .scl(scl),
		.sda_oe(host_oe));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [6:0] clamp(input logic [6:0] v);
		return (v == 7'h00) ? 7'h01 : (v > 7'h64) ? 7'h64 : v;
	endfunction : clamp
	function automatic logic [6:0] exp_pct(input int k);
		if (k == 1) return 7'h01 << ss;
		if (k == 2) return 7'h05 * ({5'h00, sp} + 7'h01);
		if (k == 3) return clamp(cs);
		return 7'h00;
	endfunction : exp_pct
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	always @(posedge core_clk) begin
		cyc++;
		if (stk === 1'b1) ticks++;
		if (cyc == 90000) begin
			fails++;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [7:0] s,
			input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic k;
		i_host.start();
		i_host.xfer({DEV, 1'b0}, 1'b1, q, k);
		chk("ack", {7'h00, k}, 8'h00);
		i_host.xfer(a, 1'b1, q, k);
		i_host.xfer(d, 1'b1, q, k);
		chk("ack", {7'h00, k}, 8'h00);
		i_host.stop();
	endtask : wr
	task automatic rchk(input string n, input logic [7:0] a,
			input logic [7:0] e);
		logic [7:0] d;
		logic k;
		i_host.start();
		i_host.xfer({DEV, 1'b0}, 1'b1, d, k);
		i_host.xfer(a, 1'b1, d, k);
		i_host.start();
		i_host.xfer({DEV, 1'b1}, 1'b1, d, k);
		i_host.xfer(8'hff, 1'b1, d, k);
		i_host.stop();
		chk(n, d, e);
	endtask : rchk
	task automatic lv(input int k);
		lvl = 4'hf >> (4 - k);
		repeat (6) @(negedge core_clk);
		chk("phase", {5'h00, ph}, 8'(k));
		chk("percent", {1'b0, pct}, {1'b0, exp_pct(k)});
		chk("trickle", {7'h00, dead_on}, {7'h00, k == 0});
	endtask : lv
	task automatic pulses(input int e);
		ticks = 0;
		repeat (8) begin
			tick = 1'b1;
			@(negedge core_clk);
			tick = 1'b0;
			repeat (3) @(negedge core_clk);
		end
		chk("ticks", 8'(ticks), 8'(e));
	endtask : pulses
	initial begin
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		rchk("fast_scale", 8'h18, 8'h64);
		rchk("input_scale", 8'h17, 8'h64);
		rchk("short_sel", 8'h0b, 8'h00);
		rchk("pre_sel", 8'h19, 8'h00);
		rchk("unmapped", 8'h40, 8'h00);
		$display("test reset values done");
		chg = 1'b1;
		go = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("go_wins", {6'h00, cm, om}, 8'h01);
		go = 1'b0;
		repeat (8) @(negedge core_clk);
		chk("charge", {6'h00, cm, ile}, 8'h03);
		go = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("no_swap", {6'h00, cm, om}, 8'h02);
		idle = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("idle_forced", {6'h00, cm, om}, 8'h00);
		idle = 1'b0;
		repeat (8) @(negedge core_clk);
		chk("go_again", {6'h00, cm, om}, 8'h01);
		go = 1'b0;
		repeat (8) @(negedge core_clk);
		chk("charge_back", {6'h00, cm, om}, 8'h02);
		$display("test modes done");
		for (int i = 0; i < 12; i++) begin
			ss = 2'(i);
			sp = 2'(i + 1);
			cs = (i < 4) ? corner[i] : 7'(rnd());
			ils = (i < 4) ? corner[3 - i] : 7'(rnd());
			wr(8'h0b, {6'h00, ss});
			wr(8'h19, {6'h00, sp});
			wr(8'h18, {1'b0, cs});
			wr(8'h17, {1'b0, ils});
			rchk("fast_scale", 8'h18, {1'b0, cs});
			rchk("input_scale", 8'h17, {1'b0, ils});
			chk("input_pct", {1'b0, ilp}, {1'b0, clamp(ils)});
			for (int k = 0; k < 5; k++) lv(k);
			lv(int'(rnd() % 32'h5));
		end
		$display("test setpoints done");
		lv(3);
		lim = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("flag", {7'h00, flag}, 8'h01);
		rchk("status", 8'h03, 8'h17);
		pulses(4);
		lim = 1'b0;
		repeat (6) @(negedge core_clk);
		pulses(8);
		lim = 1'b1;
		chg = 1'b0;
		repeat (8) @(negedge core_clk);
		chk("flag_idle", {6'h00, flag, ile}, 8'h00);
		$display("test input limit done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
